// *** bfp_popcount.v ***
`timescale 1ns/100ps

// ==========================================================================
// Population count
module bfp_popcount #(
  parameter W = 32,
  parameter CW = 6
) (
  input wire [W-1:0] i_data,
  output reg [CW-1:0] o_count
);

  integer k;

  always @* begin
    o_count = {CW{1'b0}};
    for (k = 0; k < W; k = k + 1) begin
      o_count = o_count + {{(CW-1){1'b0}}, i_data[k]};
    end
  end

endmodule // bfp_popcount

// *** bfp_regs.vh ***
`ifndef BFP_REGS_VH
`define BFP_REGS_VH

// ==========================================================================
// Operation codes
`define BFP_OP_BATCH_SET   3'h0
`define BFP_OP_DECODE      3'h1
`define BFP_OP_ENCODE      3'h2
`define BFP_OP_POP_WORD    3'h3
`define BFP_OP_POP_DWORD   3'h4
`define BFP_OP_BIT_JUDGE   3'h5
`define BFP_OP_CONTACT_LD  3'h6

// ==========================================================================
// Operand limits
`define BFP_BIT_INDEX_MAX  16'h000f
`define BFP_WORD_W         16
`define BFP_DWORD_W        32

// ==========================================================================
// Sequencer states
`define BFP_ST_IDLE        1'b0
`define BFP_ST_SET         1'b1

`endif

// *** bfp_unit.v ***
`timescale 1ns/100ps
`include "bfp_regs.vh"

// Function
// - Batch set drives count bits from base
// - Decode writes one-hot word for index 0-15
// - Decode index out of range leaves destination
// - Decode index out of range raises error
// - Encode writes position of a set bit
// - Encode prefers the lowest set bit
// - Word popcount writes count of ones
// - Double-word popcount writes 6-bit count
// - Bit judge copies indexed bit to boolean
// - Contact load drives rung from indexed bit
module bfp_unit #(
  parameter AW = 16
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_start,
  input wire i_rung_en,
  input wire [2:0] i_op,
  input wire [31:0] i_src,
  input wire [15:0] i_index,
  input wire [AW-1:0] i_dst_addr,
  output reg o_busy,
  output reg o_done,
  output reg o_word_we,
  output reg [15:0] o_word,
  output reg o_bit_we,
  output reg [AW-1:0] o_bit_addr,
  output reg o_bit_val,
  output reg o_rung,
  output reg o_op_err
);

  // ========================================================================
  // Helpers
  function in_range;
    input [15:0] idx;
    begin
      in_range = (idx <= `BFP_BIT_INDEX_MAX);
    end
  endfunction

  function [3:0] lowest_one;
    input [15:0] w;
    integer n;
    begin
      lowest_one = 4'h0;
      for (n = 15; n >= 0; n = n - 1) begin
        if (w[n]) begin
          lowest_one = n[3:0];
        end
      end
    end
  endfunction

  // ========================================================================
  // Counting
  wire [5:0] pop_count;
  wire [31:0] pop_in;

  assign pop_in = (i_op == `BFP_OP_POP_WORD) ? {16'h0000, i_src[15:0]} : i_src;

  bfp_popcount #(
    .W(`BFP_DWORD_W),
    .CW(6)
  ) u_pop (
    .i_data(pop_in),
    .o_count(pop_count)
  );

  // ========================================================================
  // Sequencer
  reg state_q;
  reg state_d;
  reg [15:0] remain_q;
  reg [15:0] remain_d;
  reg [AW-1:0] addr_q;
  reg [AW-1:0] addr_d;
  reg word_we_d;
  reg [15:0] word_d;
  reg bit_we_d;
  reg [AW-1:0] bit_addr_d;
  reg bit_val_d;
  reg rung_d;
  reg err_d;
  reg done_d;
  wire take;
  wire idx_ok;

  assign take = i_start && (state_q == `BFP_ST_IDLE);
  assign idx_ok = in_range(i_index);

  always @* begin
    state_d = state_q;
    remain_d = remain_q;
    addr_d = addr_q;
    word_we_d = 1'b0;
    word_d = o_word;
    bit_we_d = 1'b0;
    bit_addr_d = o_bit_addr;
    bit_val_d = o_bit_val;
    rung_d = o_rung;
    err_d = 1'b0;
    done_d = 1'b0;
    case (state_q)
      `BFP_ST_IDLE: begin
        if (take && !i_rung_en) begin
          done_d = 1'b1;
        end else if (take) begin
          case (i_op)
            `BFP_OP_BATCH_SET: begin
              // A negative or zero count sets nothing.
              if (i_src[15] || (i_src[15:0] == 16'h0000)) begin
                done_d = 1'b1;
              end else begin
                state_d = `BFP_ST_SET;
                remain_d = i_src[15:0];
                addr_d = i_dst_addr;
              end
            end
            `BFP_OP_DECODE: begin
              done_d = 1'b1;
              if (idx_ok) begin
                word_we_d = 1'b1;
                word_d = 16'h0001 << i_index[3:0];
              end else begin
                err_d = 1'b1;
              end
            end
            `BFP_OP_ENCODE: begin
              done_d = 1'b1;
              // An all-zero source has no position to report, so it is flagged.
              if (i_src[15:0] != 16'h0000) begin
                word_we_d = 1'b1;
                word_d = {12'h000, lowest_one(i_src[15:0])};
              end else begin
                err_d = 1'b1;
              end
            end
            `BFP_OP_POP_WORD, `BFP_OP_POP_DWORD: begin
              done_d = 1'b1;
              word_we_d = 1'b1;
              word_d = {10'h000, pop_count};
            end
            `BFP_OP_BIT_JUDGE: begin
              done_d = 1'b1;
              if (idx_ok) begin
                bit_we_d = 1'b1;
                bit_addr_d = i_dst_addr;
                bit_val_d = i_src[i_index[3:0]];
              end else begin
                err_d = 1'b1;
              end
            end
            `BFP_OP_CONTACT_LD: begin
              done_d = 1'b1;
              if (idx_ok) begin
                rung_d = i_src[i_index[3:0]];
              end else begin
                err_d = 1'b1;
              end
            end
            default: begin
              done_d = 1'b1;
              err_d = 1'b1;
            end
          endcase
        end
      end
      `BFP_ST_SET: begin
        // One bit element per cycle keeps the element store single-ported.
        bit_we_d = 1'b1;
        bit_addr_d = addr_q;
        bit_val_d = 1'b1;
        addr_d = addr_q + {{(AW-1){1'b0}}, 1'b1};
        remain_d = remain_q - 16'h0001;
        if (remain_q == 16'h0001) begin
          state_d = `BFP_ST_IDLE;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = `BFP_ST_IDLE;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= `BFP_ST_IDLE;
      remain_q <= 16'h0000;
      addr_q <= {AW{1'b0}};
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_word_we <= 1'b0;
      o_word <= 16'h0000;
      o_bit_we <= 1'b0;
      o_bit_addr <= {AW{1'b0}};
      o_bit_val <= 1'b0;
      o_rung <= 1'b0;
      o_op_err <= 1'b0;
    end else begin
      state_q <= state_d;
      remain_q <= remain_d;
      addr_q <= addr_d;
      o_busy <= (state_d == `BFP_ST_SET);
      o_done <= done_d;
      o_word_we <= word_we_d;
      o_word <= word_d;
      o_bit_we <= bit_we_d;
      o_bit_addr <= bit_addr_d;
      o_bit_val <= bit_val_d;
      o_rung <= rung_d;
      o_op_err <= err_d;
    end
  end

endmodule // bfp_unit

// *** bfp_unit_properties.sv ***
`timescale 1ns/100ps
// ==========
// Checker
module bfp_unit_properties #(
  parameter AW = 16
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_start,
  input wire i_rung_en,
  input wire [2:0] i_op,
  input wire [31:0] i_src,
  input wire [15:0] i_index,
  input wire [AW-1:0] i_dst_addr,
  input wire o_busy,
  input wire o_done,
  input wire o_word_we,
  input wire [15:0] o_word,
  input wire o_bit_we,
  input wire [AW-1:0] o_bit_addr,
  input wire o_bit_val,
  input wire o_rung,
  input wire o_op_err
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire go = i_start & ~o_busy & i_rung_en;
  wire ok = i_index < 16'h0010;
  wire [3:0] k = i_index[3:0];
  wire [3:0] w = o_word[3:0];
  batch_first_a: assert property (go && i_op == 3'h0 && $signed(i_src[15:0]) > 0 |=>
    o_busy ##1 o_bit_we && o_bit_val && o_bit_addr == $past(i_dst_addr, 2)) else $error("set");
  dec_hot_a: assert property (go && i_op == 3'h1 && ok |=> o_word_we && o_word == 16'h0001 << $past(k))
    else $error("dec");
  dec_range_a: assert property (go && i_op == 3'h1 && !ok |=> o_op_err && !o_word_we)
    else $error("dec err");
  enc_low_a: assert property (go && i_op == 3'h2 && i_src[15:0] != 16'h0000 |=> o_word_we &&
    o_word[15:4] == 12'h000 && ($past(i_src[15:0]) & ((16'h0002 << w) - 1)) == (16'h0001 << w)) else $error("enc");
  pop_word_a: assert property (go && i_op == 3'h3 |=> o_word_we && o_word == $countones($past(i_src[15:0])))
    else $error("pop");
  pop_dword_a: assert property (go && i_op == 3'h4 |=> o_word_we && o_word == $countones($past(i_src)))
    else $error("dpop");
  judge_bit_a: assert property (go && i_op == 3'h5 && ok |=> o_bit_we && o_bit_val == $past(i_src[k]) &&
    o_bit_addr == $past(i_dst_addr)) else $error("judge");
  load_rung_a: assert property (go && i_op == 3'h6 && ok |=> o_rung == $past(i_src[k]))
    else $error("load");
  load_err_a: assert property (go && i_op == 3'h6 && !ok |=> o_op_err && $stable(o_rung))
    else $error("load err");
  rung_off_a: assert property (i_start && !o_busy && !i_rung_en |=> o_done && !o_word_we && !o_bit_we &&
    !o_op_err && $stable(o_rung)) else $error("off");
endmodule // bfp_unit_properties

bind bfp_unit bfp_unit_properties #(.AW(AW)) u_chk (.*);

// *** tb_top.sv ***
`timescale 1ns/100ps
// ==========
// Bench
module tb_top;
  reg i_clk = 0, i_srst = 1, i_start = 0, i_rung_en = 0, ren = 1;
  reg [2:0] i_op = 0;
  reg [31:0] i_src = 0;
  reg [15:0] i_index = 0, i_dst_addr = 0, adr = 0;
  wire o_busy, o_done, o_word_we, o_bit_we, o_bit_val, o_rung, o_op_err;
  wire [15:0] o_word, o_bit_addr;
  integer num_errors = 0, samples_checked = 0, nw = 0, i;
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_bit_we === 1'b1) nw <= nw + 1;
  bfp_unit DUT (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(i_start),
    .i_rung_en(i_rung_en),
    .i_op(i_op),
    .i_src(i_src),
    .i_index(i_index),
    .i_dst_addr(i_dst_addr),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_word_we(o_word_we),
    .o_word(o_word),
    .o_bit_we(o_bit_we),
    .o_bit_addr(o_bit_addr),
    .o_bit_val(o_bit_val),
    .o_rung(o_rung),
    .o_op_err(o_op_err)
  );
  task chk(input [31:0] g, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Sampling 1 ns after the edge lets the registered outputs settle first.
  task req(input [2:0] op, input [31:0] s, input [15:0] x);
    integer n;
    @(posedge i_clk);
    i_start <= 1;
    i_op <= op;
    i_src <= s;
    i_index <= x;
    i_rung_en <= ren;
    i_dst_addr <= adr;
    @(posedge i_clk);
    i_start <= 0;
    #1;
    n = 0;
    while (o_done !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      #1;
      n = n + 1;
    end
    if (n == 50) chk(0, 1);
  endtask
  // The write counter is only read here, so it keeps a single driver.
  task t_batch;
    integer n0;
    adr = 16'h0040;
    n0 = nw;
    req(3'h0, 3, 0);
    chk(o_bit_addr, 16'h0042);
    @(posedge i_clk);
    #1;
    chk(nw - n0, 3);
    req(3'h0, 0, 0);
    chk(o_bit_we, 0);
    req(3'h0, 32'h0000_fffd, 0);
    @(posedge i_clk);
    #1;
    chk(nw - n0, 3);
  endtask
  task t_dec;
    for (i = 0; i < 16; i = i + 1) begin
      req(3'h1, 0, i);
      chk(o_word, 32'h1 << i);
    end
    req(3'h1, 0, 16'h0010);
    chk({o_op_err, o_word_we, o_word}, 32'h28000);
  endtask
  task t_enc;
    req(3'h2, 16'h0a08, 0);
    chk(o_word, 3);
    req(3'h2, 16'h8000, 0);
    chk(o_word, 15);
    req(3'h2, 16'h0000, 0);
    chk({o_op_err, o_word_we, o_word}, 32'h2000f);
  endtask
  task t_pop;
    req(3'h3, 32'hffff_f0f0, 0);
    chk(o_word, 8);
    req(3'h4, 32'h000f_f0ff, 0);
    chk(o_word, 16);
  endtask
  task t_judge;
    adr = 16'h0007;
    req(3'h5, 16'h0020, 5);
    chk({o_bit_we, o_bit_val, o_bit_addr}, 32'h30007);
    adr = 16'h0008;
    req(3'h5, 16'hffdf, 5);
    chk({o_bit_we, o_bit_val, o_bit_addr}, 32'h20008);
    req(3'h5, 16'hffff, 16'h0010);
    chk({o_op_err, o_bit_we, o_bit_val, o_bit_addr}, 32'h40008);
  endtask
  task t_bad_op;
    req(3'h7, 0, 0);
    chk({o_done, o_op_err, o_word_we, o_bit_we}, 32'hc);
  endtask
  task t_ld;
    req(3'h6, 16'h0020, 5);
    chk(o_rung, 1);
    req(3'h6, 16'hffdf, 5);
    chk(o_rung, 0);
    req(3'h6, 16'h0020, 5);
    chk(o_rung, 1);
    req(3'h6, 0, 16'hffff);
    chk({o_op_err, o_rung}, 3);
  endtask
  task t_off;
    ren = 0;
    req(3'h1, 0, 3);
    chk({o_done, o_word_we, o_op_err}, 4);
    req(3'h6, 0, 5);
    chk(o_rung, 1);
    ren = 1;
  endtask
  task give_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 0;
    t_batch;
    t_dec;
    t_enc;
    t_pop;
    t_judge;
    t_bad_op;
    t_ld;
    t_off;
    give_verdict;
  end
  initial begin
    #200000;
    num_errors = num_errors + 1;
    give_verdict;
  end
endmodule // tb_top
